// ---- rtl/hpi_pkg.sv ----
/*
  hpi_pkg: register offsets, field positions, masks, reset values and gain
  codes for the hybrid, power-override and event-flag register group.
  assumes: the serial control port front end delivers byte-wide accesses with
  the printed 8-bit register address.
*/
package hpi_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] HYBRID_GAIN_CTRL_OFS     = 8'h0b;
  localparam logic [7:0] POWER_OVERRIDE_CTRL_OFS  = 8'h0e;
  localparam logic [7:0] CONVERTER_POWER_CTRL_OFS = 8'h0f;
  localparam logic [7:0] TIMER_EVENT_FLAGS_OFS    = 8'h12;
  localparam logic [7:0] LINE_ALARM_FLAGS_OFS     = 8'h13;

  // ----------------------------------------------------------------
  // writable-bit masks, reserved bits read zero
  // ----------------------------------------------------------------
  localparam logic [7:0] HYBRID_GAIN_MASK     = 8'h77;
  localparam logic [7:0] POWER_OVERRIDE_MASK  = 8'h3b;
  localparam logic [7:0] CONVERTER_POWER_MASK = 8'h3f;
  localparam logic [7:0] FLAGS_MASK           = 8'hff;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] HYBRID_GAIN_RST     = 8'h00;
  localparam logic [7:0] POWER_OVERRIDE_RST  = 8'h10;
  localparam logic [7:0] CONVERTER_POWER_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST           = 8'h00;

  // ----------------------------------------------------------------
  // hybrid_gain_ctrl fields
  // ----------------------------------------------------------------
  localparam int METER_HYBRID_GAIN_LSB = 4;
  localparam int AUDIO_HYBRID_GAIN_LSB = 0;
  localparam int HYBRID_GAIN_W         = 3;
  localparam logic [2:0] GAIN_CODE_OFF = 3'h7;

  // gain in hundredths of a dB, signed
  localparam int GAIN_CDB_W = 10;
  localparam logic signed [9:0] GAIN_CDB_C0 = 10'sd408;
  localparam logic signed [9:0] GAIN_CDB_C1 = 10'sd250;
  localparam logic signed [9:0] GAIN_CDB_C2 = 10'sd116;
  localparam logic signed [9:0] GAIN_CDB_C3 = 10'sd0;
  localparam logic signed [9:0] GAIN_CDB_C4 = -10'sd102;
  localparam logic signed [9:0] GAIN_CDB_C5 = -10'sd194;
  localparam logic signed [9:0] GAIN_CDB_C6 = -10'sd277;

  // ----------------------------------------------------------------
  // power_override_ctrl fields
  // ----------------------------------------------------------------
  localparam int METER_CONV_FORCE_ON_BIT   = 5;
  localparam int BOOST_FORCE_OFF_BIT       = 4;
  localparam int MONITOR_ADC_FORCE_OFF_BIT = 3;
  localparam int DC_BIAS_FORCE_OFF_BIT     = 1;
  localparam int LINE_DRIVER_FORCE_OFF_BIT = 0;

  // ----------------------------------------------------------------
  // converter_power_ctrl fields
  // ----------------------------------------------------------------
  localparam int ADC_MANUAL_SEL_BIT       = 5;
  localparam int ADC_MANUAL_ON_BIT        = 4;
  localparam int DAC_MANUAL_SEL_BIT       = 3;
  localparam int DAC_MANUAL_ON_BIT        = 2;
  localparam int TRANSCOND_MANUAL_SEL_BIT = 1;
  localparam int TRANSCOND_MANUAL_ON_BIT  = 0;

  // ----------------------------------------------------------------
  // timer_event_flags / line_alarm_flags fields
  // ----------------------------------------------------------------
  localparam int METER_IDLE_PEND_BIT   = 7;
  localparam int METER_ACTIVE_PEND_BIT = 6;
  localparam int RING_IDLE_PEND_BIT    = 5;
  localparam int RING_ACTIVE_PEND_BIT  = 4;
  localparam int TONE2_IDLE_PEND_BIT   = 3;
  localparam int TONE2_ACTIVE_PEND_BIT = 2;
  localparam int TONE1_IDLE_PEND_BIT   = 1;
  localparam int TONE1_ACTIVE_PEND_BIT = 0;
  localparam int XSTR_ALARM_LSB        = 2;
  localparam int XSTR_ALARM_W          = 6;
  localparam int LOOP_CLOSURE_PEND_BIT = 1;
  localparam int RING_TRIP_PEND_BIT    = 0;

endpackage

// ---- rtl/hpi_w1c_flags.sv ----
/*
  hpi_w1c_flags: a byte of sticky event flags, set by hardware pulses and
  cleared by writing ones.
  assumes: set and clear inputs are synchronous to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module hpi_w1c_flags #(
  parameter int          WIDTH = 8,
  parameter logic [7:0]  RST   = 8'h00
) (
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic [WIDTH-1:0] set_i,
  input  wire logic             clr_i,
  input  wire logic [WIDTH-1:0] clr_mask_i,
  output logic      [WIDTH-1:0] flags_o
);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // set is ORed last so an event in the clear cycle survives
  wire logic [WIDTH-1:0] clr_bits;
  wire logic [WIDTH-1:0] next_flags;

  assign clr_bits   = clr_i ? clr_mask_i : '0;
  assign next_flags = (flags_o & ~clr_bits) | set_i;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      flags_o <= RST[WIDTH-1:0];
    end else begin
      flags_o <= next_flags;
    end
  end

endmodule

`default_nettype wire

// ---- rtl/hpi_regs.sv ----
/*
  hpi_regs: hybrid gain, power override, converter power and event-flag
  registers of the line interface control bank, with the power and gain
  controls they steer.
  assumes: the serial control port front end presents one byte access per
  strobe with the printed register address; event inputs are one-cycle
  pulses synchronous to clk_i; interrupt enable bytes come from the
  neighbouring enable registers.
*/
`timescale 1ns/1ps
`default_nettype none

module hpi_regs #(
  parameter bit HAS_BOOST = 1'b1
) (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // register access from the serial control port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  output logic             reg_hit_o,
  // automatic power requests from the sequencing logic
  input  wire logic        auto_meter_conv_on_i,
  input  wire logic        auto_boost_on_i,
  input  wire logic        auto_monitor_adc_on_i,
  input  wire logic        auto_dc_bias_on_i,
  input  wire logic        auto_line_driver_on_i,
  input  wire logic        auto_adc_on_i,
  input  wire logic        auto_dac_on_i,
  input  wire logic        auto_transcond_on_i,
  // event pulses
  input  wire logic        meter_idle_evt_i,
  input  wire logic        meter_active_evt_i,
  input  wire logic        ring_idle_evt_i,
  input  wire logic        ring_active_evt_i,
  input  wire logic        tone2_idle_evt_i,
  input  wire logic        tone2_active_evt_i,
  input  wire logic        tone1_idle_evt_i,
  input  wire logic        tone1_active_evt_i,
  input  wire logic [5:0]  xstr_alarm_evt_i,
  input  wire logic        loop_closure_evt_i,
  input  wire logic        ring_trip_evt_i,
  // enable bytes, same bit layout as the flag registers
  input  wire logic [7:0]  timer_irq_en_i,
  input  wire logic [7:0]  alarm_irq_en_i,
  // gain controls
  output logic      [2:0]  meter_hybrid_gain_o,
  output logic             meter_hybrid_en_o,
  output logic      [9:0]  meter_hybrid_cdb_o,
  output logic      [2:0]  audio_hybrid_gain_o,
  output logic             audio_hybrid_en_o,
  output logic      [9:0]  audio_hybrid_cdb_o,
  // effective power enables
  output logic             meter_conv_pwr_o,
  output logic             boost_pwr_o,
  output logic             monitor_adc_pwr_o,
  output logic             dc_bias_pwr_o,
  output logic             line_driver_pwr_o,
  output logic             adc_pwr_o,
  output logic             dac_pwr_o,
  output logic             transcond_pwr_o,
  // flags and masked interrupt request
  output logic      [7:0]  timer_event_flags_o,
  output logic      [7:0]  line_alarm_flags_o,
  output logic             irq_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // gain code to hundredths of a dB; off reads as zero gain
  function automatic logic [9:0] gain_cdb(input logic [2:0] code);
    logic [9:0] v;
    v = '0;
    unique case (code)
      3'h0: v = hpi_pkg::GAIN_CDB_C0;
      3'h1: v = hpi_pkg::GAIN_CDB_C1;
      3'h2: v = hpi_pkg::GAIN_CDB_C2;
      3'h3: v = hpi_pkg::GAIN_CDB_C3;
      3'h4: v = hpi_pkg::GAIN_CDB_C4;
      3'h5: v = hpi_pkg::GAIN_CDB_C5;
      3'h6: v = hpi_pkg::GAIN_CDB_C6;
      3'h7: v = '0;
    endcase
    return v;
  endfunction

  // manual select wins over the automatic request
  function automatic logic pwr_sel(input logic man_sel, input logic man_on, input logic auto_on);
    return man_sel ? man_on : auto_on;
  endfunction

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [7:0] hybrid_gain_ctrl;
  logic [7:0] power_override_ctrl;
  logic [7:0] converter_power_ctrl;
  logic [7:0] timer_event_flags;
  logic [7:0] line_alarm_flags;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire logic sel_hybrid;
  wire logic sel_pwr1;
  wire logic sel_pwr2;
  wire logic sel_flag1;
  wire logic sel_flag2;
  wire logic sel_any;

  assign sel_hybrid = (reg_addr_i == hpi_pkg::HYBRID_GAIN_CTRL_OFS);
  assign sel_pwr1   = (reg_addr_i == hpi_pkg::POWER_OVERRIDE_CTRL_OFS);
  assign sel_pwr2   = (reg_addr_i == hpi_pkg::CONVERTER_POWER_CTRL_OFS);
  assign sel_flag1  = (reg_addr_i == hpi_pkg::TIMER_EVENT_FLAGS_OFS);
  assign sel_flag2  = (reg_addr_i == hpi_pkg::LINE_ALARM_FLAGS_OFS);
  assign sel_any    = sel_hybrid | sel_pwr1 | sel_pwr2 | sel_flag1 | sel_flag2;

  // handshake: combinational, tells the port front end this byte is ours
  assign reg_hit_o  = sel_any & (reg_wr_i | reg_rd_i);

  // ----------------------------------------------------------------
  // write data shaping
  // ----------------------------------------------------------------
  wire logic [7:0] boost_keep;
  wire logic [7:0] next_hybrid;
  wire logic [7:0] next_pwr1;
  wire logic [7:0] next_pwr2;

  // without the converter the force-off bit is pinned high
  assign boost_keep  = HAS_BOOST ? 8'h00 : (8'h01 << hpi_pkg::BOOST_FORCE_OFF_BIT);
  assign next_hybrid = reg_wdata_i & hpi_pkg::HYBRID_GAIN_MASK;
  assign next_pwr1   = (reg_wdata_i & hpi_pkg::POWER_OVERRIDE_MASK) | boost_keep;
  assign next_pwr2   = reg_wdata_i & hpi_pkg::CONVERTER_POWER_MASK;

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      hybrid_gain_ctrl     <= hpi_pkg::HYBRID_GAIN_RST;
      power_override_ctrl  <= hpi_pkg::POWER_OVERRIDE_RST;
      converter_power_ctrl <= hpi_pkg::CONVERTER_POWER_RST;
    end else if (reg_wr_i) begin
      if (sel_hybrid) begin
        hybrid_gain_ctrl <= next_hybrid;
      end
      if (sel_pwr1) begin
        power_override_ctrl <= next_pwr1;
      end
      if (sel_pwr2) begin
        converter_power_ctrl <= next_pwr2;
      end
    end
  end

  // ----------------------------------------------------------------
  // event flags
  // ----------------------------------------------------------------
  wire logic [7:0] timer_set;
  wire logic [7:0] alarm_set;

  assign timer_set = {meter_idle_evt_i, meter_active_evt_i,
                      ring_idle_evt_i, ring_active_evt_i,
                      tone2_idle_evt_i, tone2_active_evt_i,
                      tone1_idle_evt_i, tone1_active_evt_i};
  // transistor six lands in bit 7, transistor one in bit 2
  assign alarm_set = {xstr_alarm_evt_i, loop_closure_evt_i, ring_trip_evt_i};

  hpi_w1c_flags #(
    .WIDTH (8),
    .RST   (hpi_pkg::FLAGS_RST)
  ) u_timer_flags (
    .clk_i      (clk_i),
    .rst_b_i    (rst_b_i),
    .set_i      (timer_set),
    .clr_i      (reg_wr_i & sel_flag1),
    .clr_mask_i (reg_wdata_i),
    .flags_o    (timer_event_flags)
  );

  hpi_w1c_flags #(
    .WIDTH (8),
    .RST   (hpi_pkg::FLAGS_RST)
  ) u_alarm_flags (
    .clk_i      (clk_i),
    .rst_b_i    (rst_b_i),
    .set_i      (alarm_set),
    .clr_i      (reg_wr_i & sel_flag2),
    .clr_mask_i (reg_wdata_i),
    .flags_o    (line_alarm_flags)
  );

  assign timer_event_flags_o = timer_event_flags;
  assign line_alarm_flags_o  = line_alarm_flags;

  // level request; masking never touches the flags themselves
  assign irq_o = |(timer_event_flags & timer_irq_en_i) |
                 |(line_alarm_flags & alarm_irq_en_i);

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  wire logic [7:0] read_mux;

  // unmapped addresses read zero
  assign read_mux = sel_hybrid ? hybrid_gain_ctrl :
                    sel_pwr1   ? power_override_ctrl :
                    sel_pwr2   ? converter_power_ctrl :
                    sel_flag1  ? timer_event_flags :
                    sel_flag2  ? line_alarm_flags : 8'h00;

  // read data registered, held until the next read
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= read_mux;
    end
  end

  // ----------------------------------------------------------------
  // hybrid gain outputs
  // ----------------------------------------------------------------
  wire logic [2:0] meter_code;
  wire logic [2:0] audio_code;

  assign meter_code = hybrid_gain_ctrl[hpi_pkg::METER_HYBRID_GAIN_LSB +: hpi_pkg::HYBRID_GAIN_W];
  assign audio_code = hybrid_gain_ctrl[hpi_pkg::AUDIO_HYBRID_GAIN_LSB +: hpi_pkg::HYBRID_GAIN_W];

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      meter_hybrid_gain_o <= 3'h0;
      meter_hybrid_en_o   <= 1'b0;
      meter_hybrid_cdb_o  <= 10'h000;
      audio_hybrid_gain_o <= 3'h0;
      audio_hybrid_en_o   <= 1'b0;
      audio_hybrid_cdb_o  <= 10'h000;
    end else begin
      meter_hybrid_gain_o <= meter_code;
      meter_hybrid_en_o   <= (meter_code != hpi_pkg::GAIN_CODE_OFF);
      meter_hybrid_cdb_o  <= gain_cdb(meter_code);
      audio_hybrid_gain_o <= audio_code;
      audio_hybrid_en_o   <= (audio_code != hpi_pkg::GAIN_CODE_OFF);
      audio_hybrid_cdb_o  <= gain_cdb(audio_code);
    end
  end

  // ----------------------------------------------------------------
  // power overrides
  // ----------------------------------------------------------------
  wire logic next_meter_conv;
  wire logic next_boost;
  wire logic next_monitor_adc;
  wire logic next_dc_bias;
  wire logic next_line_driver;
  wire logic next_adc;
  wire logic next_dac;
  wire logic next_transcond;

  assign next_meter_conv  = power_override_ctrl[hpi_pkg::METER_CONV_FORCE_ON_BIT] |
                            auto_meter_conv_on_i;
  assign next_boost       = ~power_override_ctrl[hpi_pkg::BOOST_FORCE_OFF_BIT] &
                            auto_boost_on_i;
  assign next_monitor_adc = ~power_override_ctrl[hpi_pkg::MONITOR_ADC_FORCE_OFF_BIT] &
                            auto_monitor_adc_on_i;
  assign next_dc_bias     = ~power_override_ctrl[hpi_pkg::DC_BIAS_FORCE_OFF_BIT] &
                            auto_dc_bias_on_i;
  assign next_line_driver = ~power_override_ctrl[hpi_pkg::LINE_DRIVER_FORCE_OFF_BIT] &
                            auto_line_driver_on_i;
  assign next_adc         = pwr_sel(converter_power_ctrl[hpi_pkg::ADC_MANUAL_SEL_BIT],
                                    converter_power_ctrl[hpi_pkg::ADC_MANUAL_ON_BIT],
                                    auto_adc_on_i);
  assign next_dac         = pwr_sel(converter_power_ctrl[hpi_pkg::DAC_MANUAL_SEL_BIT],
                                    converter_power_ctrl[hpi_pkg::DAC_MANUAL_ON_BIT],
                                    auto_dac_on_i);
  assign next_transcond   = pwr_sel(converter_power_ctrl[hpi_pkg::TRANSCOND_MANUAL_SEL_BIT],
                                    converter_power_ctrl[hpi_pkg::TRANSCOND_MANUAL_ON_BIT],
                                    auto_transcond_on_i);

  // registered so the analog enables never see decode glitches
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      meter_conv_pwr_o  <= 1'b0;
      boost_pwr_o       <= 1'b0;
      monitor_adc_pwr_o <= 1'b0;
      dc_bias_pwr_o     <= 1'b0;
      line_driver_pwr_o <= 1'b0;
      adc_pwr_o         <= 1'b0;
      dac_pwr_o         <= 1'b0;
      transcond_pwr_o   <= 1'b0;
    end else begin
      meter_conv_pwr_o  <= next_meter_conv;
      boost_pwr_o       <= next_boost & HAS_BOOST;
      monitor_adc_pwr_o <= next_monitor_adc;
      dc_bias_pwr_o     <= next_dc_bias;
      line_driver_pwr_o <= next_line_driver;
      adc_pwr_o         <= next_adc;
      dac_pwr_o         <= next_dac;
      transcond_pwr_o   <= next_transcond;
    end
  end

endmodule

`default_nettype wire

// ---- verif/hpi_regs_assertions.sv ----
/*
  hpi_regs_assertions: port-level checks on reads, flags, irq, gain and power.
  assumes: one clock, synchronous active-low reset, bound to hpi_regs.
*/
`timescale 1ns/1ps
`default_nettype none
module hpi_regs_assertions #(
  parameter bit HAS_BOOST = 1'b1
) (
  input wire logic       clk_i,
  input wire logic       rst_b_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       auto_meter_conv_on_i,
  input wire logic       auto_boost_on_i,
  input wire logic [5:0] xstr_alarm_evt_i,
  input wire logic       ring_trip_evt_i,
  input wire logic [7:0] timer_irq_en_i,
  input wire logic [7:0] alarm_irq_en_i,
  input wire logic [2:0] meter_hybrid_gain_o,
  input wire logic       meter_hybrid_en_o,
  input wire logic [2:0] audio_hybrid_gain_o,
  input wire logic       audio_hybrid_en_o,
  input wire logic       meter_conv_pwr_o,
  input wire logic       boost_pwr_o,
  input wire logic [7:0] timer_event_flags_o,
  input wire logic [7:0] line_alarm_flags_o,
  input wire logic       irq_o
);
  // ------------------------------------------------------------
  // helpers and properties
  // ------------------------------------------------------------
  logic      clr7_q;
  wire logic mapped = reg_addr_i inside {8'h0b, 8'h0e, 8'h0f, 8'h12, 8'h13};
  always_ff @(posedge clk_i) clr7_q <= reg_wr_i && reg_addr_i == 8'h12 && reg_wdata_i[7];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_trip_clr;
    reg_wr_i && reg_addr_i == 8'h13 && reg_wdata_i[0];
  endsequence
  // outputs are registered, so skip the first edge after reset
  a_unmapped_zero: assert property (reg_rd_i && !mapped |=> reg_rdata_o == 8'h00) else $error("bad unmapped");
  a_rsvd_pwr: assert property (reg_rd_i && reg_addr_i == 8'h0e |=> (reg_rdata_o & 8'hc4) == 8'h00) else $error("rsvd");
  a_trip_sticky: assert property (ring_trip_evt_i |=> line_alarm_flags_o[0]) else $error("trip lost");
  a_trip_clear: assert property (s_trip_clr ##0 !ring_trip_evt_i |=> !line_alarm_flags_o[0]) else $error("no clr");
  a_xstr_map: assert property (xstr_alarm_evt_i != 6'h00 |=> (line_alarm_flags_o[7:2] & $past(xstr_alarm_evt_i))
    == $past(xstr_alarm_evt_i)) else $error("alarm map");
  a_no_silent: assert property ($past(rst_b_i) && $fell(timer_event_flags_o[7]) |-> clr7_q) else $error("fell");
  a_irq_mask: assert property (irq_o == |((timer_event_flags_o & timer_irq_en_i) | (line_alarm_flags_o & alarm_irq_en_i)))
    else $error("irq mask");
  a_hyb_off: assert property ($past(rst_b_i) |-> meter_hybrid_en_o == (meter_hybrid_gain_o != 3'h7)
    && audio_hybrid_en_o == (audio_hybrid_gain_o != 3'h7)) else $error("hybrid en");
  a_meter_on: assert property ($past(rst_b_i) && $past(auto_meter_conv_on_i) |-> meter_conv_pwr_o) else $error("m");
  a_boost_auto: assert property (boost_pwr_o |-> HAS_BOOST && $past(auto_boost_on_i)) else $error("boost");
endmodule
bind hpi_regs hpi_regs_assertions #(.HAS_BOOST(HAS_BOOST)) u_chk (.*);
`default_nettype wire

// ---- verif/hpi_host.sv ----
/*
  hpi_host: host side of the register port, one byte per strobe.
  assumes: the bench calls its tasks one at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module hpi_host (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output logic      [7:0] addr_o = 8'h00,
  output logic      [7:0] wdata_o = 8'h00,
  output logic            wr_o = 1'b0,
  output logic            rd_o = 1'b0
);
  // ------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------
  // released lines go inverted so stale values are never trusted
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    addr_o  <= ~a;
    wdata_o <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    addr_o <= ~a;
    @(negedge clk_i);
    d = rdata_i;
  endtask
endmodule
`default_nettype wire

// ---- verif/hpi_regs_tb.sv ----
/*
  hpi_regs_tb: self-checking bench, integer model compared at every result.
  assumes: hpi_host drives the register port; 50 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module hpi_regs_tb;
  // ------------------------------------------------------------
  // signals and model state
  // ------------------------------------------------------------
  logic       clk_i = 1'b0, rst_b_i = 1'b0, reg_wr_i, reg_rd_i, reg_hit_o, irq_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, timer_event_flags_o, line_alarm_flags_o;
  logic [7:0] timer_irq_en_i = 8'h00, alarm_irq_en_i = 8'h00, au = 8'h00, tev = 8'h00, aev = 8'h00;
  logic [2:0] meter_hybrid_gain_o, audio_hybrid_gain_o;
  logic [9:0] meter_hybrid_cdb_o, audio_hybrid_cdb_o;
  logic [5:0] xstr_alarm_evt_i;
  logic       meter_hybrid_en_o, audio_hybrid_en_o, loop_closure_evt_i, ring_trip_evt_i;
  logic       meter_idle_evt_i, meter_active_evt_i, ring_idle_evt_i, ring_active_evt_i, tone2_idle_evt_i;
  logic       tone2_active_evt_i, tone1_idle_evt_i, tone1_active_evt_i, auto_meter_conv_on_i, auto_boost_on_i;
  logic       auto_monitor_adc_on_i, auto_dc_bias_on_i, auto_line_driver_on_i, auto_adc_on_i, auto_dac_on_i;
  logic       auto_transcond_on_i, meter_conv_pwr_o, boost_pwr_o, monitor_adc_pwr_o, dc_bias_pwr_o;
  logic       line_driver_pwr_o, adc_pwr_o, dac_pwr_o, transcond_pwr_o;
  int         err_total = 0, n_tests = 0, hyb, pw1, pw2, tf, la;
  int         cdb[8] = '{408, 250, 116, 0, -102, -194, -277, 0};
  logic [7:0] ad[6] = '{8'h0b, 8'h0e, 8'h0f, 8'h12, 8'h13, 8'h0c};
  assign {auto_meter_conv_on_i, auto_boost_on_i, auto_monitor_adc_on_i, auto_dc_bias_on_i, auto_line_driver_on_i,
          auto_adc_on_i, auto_dac_on_i, auto_transcond_on_i} = au;
  assign {meter_idle_evt_i, meter_active_evt_i, ring_idle_evt_i, ring_active_evt_i, tone2_idle_evt_i,
          tone2_active_evt_i, tone1_idle_evt_i, tone1_active_evt_i} = tev;
  assign {xstr_alarm_evt_i, loop_closure_evt_i, ring_trip_evt_i} = aev;
  always #10 clk_i = ~clk_i;
  hpi_regs dut (.*);
  hpi_host host (.clk_i(clk_i), .rdata_i(reg_rdata_o), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i),
                 .wr_o(reg_wr_i), .rd_o(reg_rd_i));
  // second copy without the converter, fed the same stimulus
  logic [7:0] nb_rdata;
  logic       nb_boost;
  hpi_regs #(.HAS_BOOST(1'b0)) dut_nb (.*, .reg_rdata_o(nb_rdata), .boost_pwr_o(nb_boost), .reg_hit_o(),
    .meter_hybrid_gain_o(), .meter_hybrid_en_o(), .meter_hybrid_cdb_o(), .audio_hybrid_gain_o(),
    .audio_hybrid_en_o(), .audio_hybrid_cdb_o(), .meter_conv_pwr_o(), .monitor_adc_pwr_o(), .dc_bias_pwr_o(),
    .line_driver_pwr_o(), .adc_pwr_o(), .dac_pwr_o(), .transcond_pwr_o(), .timer_event_flags_o(),
    .line_alarm_flags_o(), .irq_o());
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input string n, input int e, input logic [9:0] g);
    n_tests++;
    if (g !== e[9:0]) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", n, e[9:0], g);
    end
  endtask
  function automatic int mdl(input logic [7:0] a);
    case (a)
      8'h0b: return hyb;
      8'h0e: return pw1;
      8'h0f: return pw2;
      8'h12: return tf;
      8'h13: return la;
      default: return 0;
    endcase
  endfunction
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d);
    case (a)
      8'h0b: hyb = d & 8'h77;
      8'h0e: pw1 = d & 8'h3b;
      8'h0f: pw2 = d & 8'h3f;
      8'h12: tf = tf & ~d;
      8'h13: la = la & ~d;
      default: ;
    endcase
  endtask
  task automatic r(input logic [7:0] a);
    logic [7:0] g;
    fork
      host.rd(a, g);
      begin
        @(posedge clk_i);
        @(negedge clk_i);
        chk("hit", a inside {8'h0b, 8'h0e, 8'h0f, 8'h12, 8'h13}, {9'h000, reg_hit_o});
      end
    join
    chk("rdata", mdl(a), {2'b00, g});
    chk("nb_rdata", mdl(a) | ((a == 8'h0e) ? 8'h10 : 8'h00), {2'b00, nb_rdata});
  endtask
  task automatic ev(input logic [7:0] t, input logic [7:0] a);
    @(posedge clk_i);
    tev <= t;
    aev <= a;
    @(posedge clk_i);
    tev <= 8'h00;
    aev <= 8'h00;
  endtask
  task automatic fc;
    @(negedge clk_i);
    chk("tflags", tf, {2'b00, timer_event_flags_o});
    chk("aflags", la, {2'b00, line_alarm_flags_o});
    chk("irq", |((tf & timer_irq_en_i) | (la & alarm_irq_en_i)), {9'h000, irq_o});
  endtask
  task automatic end_sim;
    if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ------------------------------------------------------------
  // sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    logic [7:0] a8, d8, e8;
    void'($urandom(32'heae98d61));
    repeat (2) begin
      @(posedge clk_i);
      rst_b_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      rst_b_i <= 1'b1;
      {hyb, pw1, pw2, tf, la} = {32'd0, 32'h10, 96'd0};
      foreach (ad[i]) r(ad[i]);
      repeat (30) begin
        a8 = ad[$urandom % 6];
        w(a8, 8'($urandom));
        r(a8);
      end
    end
    for (int c = 0; c < 8; c++) begin
      w(8'h0b, {1'b1, 3'(c), 1'b1, 3'(7 - c)});
      repeat (2) @(negedge clk_i);
      chk("mcdb", cdb[c], meter_hybrid_cdb_o);
      chk("acdb", cdb[7 - c], audio_hybrid_cdb_o);
      chk("gains", {c != 7, 3'(c), c != 0, 3'(7 - c)}, {2'b00, meter_hybrid_en_o, meter_hybrid_gain_o,
          audio_hybrid_en_o, audio_hybrid_gain_o});
      r(8'h0b);
    end
    repeat (40) begin
      w(8'h0e, 8'($urandom));
      w(8'h0f, 8'($urandom));
      au <= 8'($urandom);
      repeat (2) @(negedge clk_i);
      e8 = {pw1[5] | au[7], !pw1[4] & au[6], !pw1[3] & au[5], !pw1[1] & au[4], !pw1[0] & au[3],
            pw2[5] ? pw2[4] : au[2], pw2[3] ? pw2[2] : au[1], pw2[1] ? pw2[0] : au[0]};
      chk("pwr", e8, {2'b00, meter_conv_pwr_o, boost_pwr_o, monitor_adc_pwr_o, dc_bias_pwr_o, line_driver_pwr_o,
          adc_pwr_o, dac_pwr_o, transcond_pwr_o});
      chk("nb_boost", 0, {9'h000, nb_boost});
    end
    repeat (40) begin
      @(posedge clk_i);
      timer_irq_en_i <= 8'($urandom);
      alarm_irq_en_i <= 8'($urandom);
      a8 = 8'($urandom);
      d8 = 8'($urandom);
      ev(a8, d8);
      tf = tf | a8;
      la = la | d8;
      fc();
      w(8'h12, 8'($urandom));
      fc();
      d8 = 8'($urandom);
      // clear and event land on the same edge
      fork
        host.wr(8'h13, 8'hff);
        ev(8'h00, d8);
      join
      la = d8;
      fc();
      r(8'h13);
    end
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    end_sim();
  end
endmodule
`default_nettype wire
